//--- core/oscd_ctrl.sv
// oscillator switch control, doze ratio and fractional divider settings
// assumes oscillator status pins are synchronous unless noted; async ones
// (ready, lock, new-clock tick) pass two flip-flops here
// What this block does
// - fail monitor detection sets clock-fail flag
// - sleep-keep bit keeps primary running in Sleep
// - secondary-enable bit drives secondary oscillator
// - switch request starts switch; zero means done
// - pin lock changes only after unlock
// - PLL lock reads zero in switch/non-PLL
// - source fields reset from boot configuration
// - interrupt clears ratio enable when recover set
// - ratio field 1:2^n, resets to 011
// - ratio applies only while ratio enable set
// - divider source field selects divider input
// - postscale field divides PLL branch 1-8
// - PLL runs when forced or PLL source
// - tune code is signed offset
// - divisor is half-period, resets to one
// - zero divisor passes source undivided
// - nine-bit fraction adds n/512 per half-period
// - primary submode fixed by configuration only
// - switching enabled only when config bit zero
// - switching disabled: next field ignored
// - switching disabled: request ignored, reads zero
// - same source request aborts and clears
// - wait ten new-clock cycles before change-over
//
// Chosen here: the register addresses and the strobed register port.
module oscd_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire oscd_pkg::oscd_req_t bus_req,
    output logic [15:0] rdata,
    // configuration straps
    input wire logic [2:0] boot_source_config,
    input wire logic switch_config_bit,
    input wire logic pin_lock_one_way,
    input wire logic [1:0] primary_submode_config,
    // events and oscillator status
    input wire logic fail_safe_monitor_event,
    input wire logic interrupt_event,
    input wire logic new_osc_stable_async,
    input wire logic new_clock_tick_async,
    input wire logic pll_lock_async,
    // oscillator controls
    output logic [2:0] active_source,
    output logic [2:0] switch_target,
    output logic switch_busy,
    output logic primary_sleep_keep,
    output logic secondary_osc_enable,
    output logic pll_run,
    output logic [1:0] primary_submode,
    output logic pin_map_lock,
    // divider and tuning controls
    output logic [2:0] cpu_ratio_log2,
    output logic [2:0] divider_source_field,
    output logic [3:0] pll_postscale_div,
    output logic [1:0] pll_postscale_field,
    output logic [5:0] fast_rc_tune_code,
    output logic [14:0] half_period_divisor,
    output logic [8:0] fraction_addend,
    output logic divider_bypass
);
    // control registers
    logic [2:0] current_source_field_r;
    logic [2:0] next_source_field_r;
    logic switch_request_r;
    logic clock_fail_flag_r;
    logic primary_sleep_keep_r;
    logic secondary_osc_enable_r;
    logic pin_map_lock_r;
    logic recover_on_interrupt_r;
    logic [2:0] ratio_field_r;
    logic ratio_enable_r;
    logic [2:0] divider_source_field_r;
    logic [1:0] pll_postscale_field_r;
    logic pll_force_on_r;
    logic [5:0] tune_r;
    logic [14:0] divisor_r;
    logic [8:0] fraction_r;
    logic [1:0] submode_r;
    logic boot_done_r;       // straps caught after reset release
    logic switch_en_r;       // latched switching enable
    logic [15:0] rdata_r;
    // unlock tracking: 0 idle, 1 first key seen, 2 armed
    logic [1:0] hi_unlock_r;
    logic [1:0] lo_unlock_r;
    // synchronisers
    logic [1:0] stable_sync_r;
    logic [1:0] tick_sync_r;
    logic [1:0] lock_sync_r;
    logic tick_prev_r;
    logic [3:0] settle_cnt_r;
    logic lock_seen;
    logic tick_edge;
    logic wr_ctl;
    logic src_is_pll;
    logic same_src;
    logic switch_done;

    // write decode for the oscillator control register
    assign wr_ctl = bus_req.wr && bus_req.addr == oscd_pkg::ADDR_OSC_CONTROL;
    // abort when target equals current
    assign same_src = next_source_field_r == current_source_field_r;
    assign src_is_pll = current_source_field_r == oscd_pkg::SRC_PRI_PLL
        || current_source_field_r == oscd_pkg::SRC_FRC_PLL;
    assign tick_edge = tick_sync_r[1] ^ tick_prev_r;
    // completion: ten new-clock ticks after stable
    assign switch_done = switch_request_r && !same_src
        && settle_cnt_r == oscd_pkg::SETTLE_CYCLES;

    // async status synchronisers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stable_sync_r <= 2'h0;
            tick_sync_r <= 2'h0;
            lock_sync_r <= 2'h0;
            tick_prev_r <= 1'b0;
        end else begin
            stable_sync_r <= {stable_sync_r[0], new_osc_stable_async};
            tick_sync_r <= {tick_sync_r[0], new_clock_tick_async};
            lock_sync_r <= {lock_sync_r[0], pll_lock_async};
            tick_prev_r <= tick_sync_r[1];
        end
    end

    // configuration straps caught once after reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            boot_done_r <= 1'b0;
            switch_en_r <= 1'b0;
            submode_r <= 2'h0;
        end else if (!boot_done_r) begin
            boot_done_r <= 1'b1;
            switch_en_r <= !switch_config_bit;
            submode_r <= primary_submode_config;
        end
    end

    // unlock key sequences, one per byte; any other write disarms
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hi_unlock_r <= 2'h0;
            lo_unlock_r <= 2'h0;
        end else if (bus_req.wr) begin
            if (wr_ctl && bus_req.wdata[15:8] == oscd_pkg::KEY_HI_A) begin
                hi_unlock_r <= 2'h1;
            end else if (wr_ctl && hi_unlock_r == 2'h1
                && bus_req.wdata[15:8] == oscd_pkg::KEY_HI_B) begin
                hi_unlock_r <= 2'h2;
            end else begin
                hi_unlock_r <= 2'h0;
            end
            if (wr_ctl && bus_req.wdata[7:0] == oscd_pkg::KEY_LO_A) begin
                lo_unlock_r <= 2'h1;
            end else if (wr_ctl && lo_unlock_r == 2'h1
                && bus_req.wdata[7:0] == oscd_pkg::KEY_LO_B) begin
                lo_unlock_r <= 2'h2;
            end else begin
                lo_unlock_r <= 2'h0;
            end
        end
    end

    // source fields; only an unlocked high-byte write moves next
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            current_source_field_r <= 3'h0;
            next_source_field_r <= 3'h0;
        end else if (!boot_done_r) begin
            current_source_field_r <= boot_source_config;
            next_source_field_r <= boot_source_config;
        end else begin
            if (switch_done) begin
                current_source_field_r <= next_source_field_r;
            end
            if (wr_ctl && hi_unlock_r == 2'h2 && !switch_request_r) begin
                next_source_field_r <=
                    bus_req.wdata[oscd_pkg::NEXT_SRC_LSB +: 3];
            end
        end
    end

    // switch request and settle counter
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            switch_request_r <= 1'b0;
            settle_cnt_r <= 4'h0;
        end else if (!switch_en_r) begin
            switch_request_r <= 1'b0;
            settle_cnt_r <= 4'h0;
        end else if (switch_request_r) begin
            if (same_src || switch_done) begin
                switch_request_r <= 1'b0;
                settle_cnt_r <= 4'h0;
            end else if (stable_sync_r[1] && tick_edge) begin
                settle_cnt_r <= settle_cnt_r + 4'h1;
            end
        end else if (wr_ctl && lo_unlock_r == 2'h2
            && bus_req.wdata[oscd_pkg::SWITCH_REQ_BIT]) begin
            switch_request_r <= 1'b1;
            settle_cnt_r <= 4'h0;
        end
    end

    // low-byte control bits; fail flag set wins over clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clock_fail_flag_r <= 1'b0;
            primary_sleep_keep_r <= 1'b0;
            secondary_osc_enable_r <= 1'b0;
            pin_map_lock_r <= 1'b0;
        end else begin
            if (fail_safe_monitor_event) begin
                clock_fail_flag_r <= 1'b1;
            end else if (switch_request_r && !same_src
                && settle_cnt_r == 4'h0) begin
                clock_fail_flag_r <= 1'b0; // valid switch clears it
            end else if (wr_ctl && lo_unlock_r == 2'h2
                && !bus_req.wdata[oscd_pkg::CLK_FAIL_BIT]) begin
                clock_fail_flag_r <= 1'b0;
            end
            if (wr_ctl && lo_unlock_r == 2'h2) begin
                primary_sleep_keep_r <=
                    bus_req.wdata[oscd_pkg::SLEEP_KEEP_BIT];
                secondary_osc_enable_r <=
                    bus_req.wdata[oscd_pkg::SEC_EN_BIT];
                // one-way lock refuses clearing once set
                if (!(pin_lock_one_way && pin_map_lock_r)) begin
                    pin_map_lock_r <=
                        bus_req.wdata[oscd_pkg::PIN_LOCK_BIT];
                end
            end
        end
    end

    // doze ratio control; interrupt recovery wins over a write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            recover_on_interrupt_r <= 1'b0;
            ratio_field_r <= oscd_pkg::RATIO_RESET;
            ratio_enable_r <= 1'b0;
            divider_source_field_r <= 3'h0;
            pll_postscale_field_r <= 2'h0;
            pll_force_on_r <= 1'b0;
        end else begin
            if (bus_req.wr
                && bus_req.addr == oscd_pkg::ADDR_CLOCK_DIVIDER_CTRL) begin
                recover_on_interrupt_r <= bus_req.wdata[oscd_pkg::ROI_BIT];
                ratio_field_r <= bus_req.wdata[oscd_pkg::RATIO_LSB +: 3];
                ratio_enable_r <= bus_req.wdata[oscd_pkg::RATIO_EN_BIT];
                divider_source_field_r <=
                    bus_req.wdata[oscd_pkg::DIV_SRC_LSB +: 3];
                pll_postscale_field_r <=
                    bus_req.wdata[oscd_pkg::POSTSCALE_LSB +: 2];
                pll_force_on_r <= bus_req.wdata[oscd_pkg::PLL_FORCE_BIT];
            end
            if (interrupt_event && recover_on_interrupt_r) begin
                ratio_enable_r <= 1'b0;
            end
        end
    end

    // tune, divisor and fraction registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tune_r <= 6'h00;
            divisor_r <= oscd_pkg::DIVISOR_RESET;
            fraction_r <= 9'h000;
        end else if (bus_req.wr) begin
            if (bus_req.addr == oscd_pkg::ADDR_FAST_RC_TUNE) begin
                tune_r <= bus_req.wdata[5:0];
            end else if (bus_req.addr == oscd_pkg::ADDR_HALF_PERIOD_DIVISOR)
            begin
                divisor_r <= bus_req.wdata[14:0];
            end else if (bus_req.addr == oscd_pkg::ADDR_FRACTION_ADDEND) begin
                fraction_r <= bus_req.wdata[oscd_pkg::FRAC_LSB +: 9];
            end
        end
    end

    // PLL lock is forced low during switches and non-PLL modes
    assign lock_seen = lock_sync_r[1] && src_is_pll
        && !switch_request_r;

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 16'h0000;
        end else if (bus_req.rd) begin
            if (bus_req.addr == oscd_pkg::ADDR_OSC_CONTROL) begin
                rdata_r <= {1'b0, current_source_field_r, 1'b0,
                    next_source_field_r, 1'b0, pin_map_lock_r, lock_seen,
                    1'b0, clock_fail_flag_r, primary_sleep_keep_r,
                    secondary_osc_enable_r, switch_request_r};
            end else if (bus_req.addr == oscd_pkg::ADDR_CLOCK_DIVIDER_CTRL)
            begin
                rdata_r <= {recover_on_interrupt_r, ratio_field_r,
                    ratio_enable_r, divider_source_field_r,
                    pll_postscale_field_r, pll_force_on_r, 5'h00};
            end else if (bus_req.addr == oscd_pkg::ADDR_FAST_RC_TUNE) begin
                rdata_r <= {10'h000, tune_r};
            end else if (bus_req.addr == oscd_pkg::ADDR_HALF_PERIOD_DIVISOR)
            begin
                rdata_r <= {1'b0, divisor_r};
            end else if (bus_req.addr == oscd_pkg::ADDR_FRACTION_ADDEND) begin
                rdata_r <= {fraction_r, 7'h00};
            end else begin
                rdata_r <= 16'h0000;
            end
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    // outputs
    assign rdata = rdata_r;
    // next field drives nothing while switching is off
    assign switch_target = switch_en_r ? next_source_field_r
        : current_source_field_r;
    assign active_source = current_source_field_r;
    assign switch_busy = switch_request_r;
    assign primary_sleep_keep = primary_sleep_keep_r;
    assign secondary_osc_enable = secondary_osc_enable_r;
    assign pll_run = pll_force_on_r || src_is_pll;
    assign primary_submode = submode_r;
    assign pin_map_lock = pin_map_lock_r;
    assign cpu_ratio_log2 = ratio_enable_r ? ratio_field_r : 3'h0;
    assign divider_source_field = divider_source_field_r;
    assign pll_postscale_field = pll_postscale_field_r;
    assign pll_postscale_div = 4'h1 << pll_postscale_field_r;
    assign fast_rc_tune_code = tune_r;
    assign half_period_divisor = divisor_r;
    assign fraction_addend = fraction_r;
    assign divider_bypass = divisor_r == 15'h0000;
endmodule

//--- core/oscd_pkg.sv
// package for the oscillator switch and clock divider control block
// assumes a 16-bit register port with one-cycle read latency
package oscd_pkg;
    // register indices on the plain port
    localparam logic [2:0] ADDR_OSC_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_CLOCK_DIVIDER_CTRL = 3'h1;
    localparam logic [2:0] ADDR_FAST_RC_TUNE = 3'h2;
    localparam logic [2:0] ADDR_HALF_PERIOD_DIVISOR = 3'h3;
    localparam logic [2:0] ADDR_FRACTION_ADDEND = 3'h4;
    // osc_control field positions
    localparam int CUR_SRC_LSB = 12;
    localparam int NEXT_SRC_LSB = 8;
    localparam int PIN_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int CLK_FAIL_BIT = 3;
    localparam int SLEEP_KEEP_BIT = 2;
    localparam int SEC_EN_BIT = 1;
    localparam int SWITCH_REQ_BIT = 0;
    // clock_divider_ctrl field positions, then the fraction_addend field
    localparam int ROI_BIT = 15;
    localparam int RATIO_LSB = 12;
    localparam int RATIO_EN_BIT = 11;
    localparam int DIV_SRC_LSB = 8;
    localparam int POSTSCALE_LSB = 6;
    localparam int PLL_FORCE_BIT = 5;
    localparam int FRAC_LSB = 7;
    // unlock keys for the high and low byte
    localparam logic [7:0] KEY_HI_A = 8'h78;
    localparam logic [7:0] KEY_HI_B = 8'h9A;
    localparam logic [7:0] KEY_LO_A = 8'h46;
    localparam logic [7:0] KEY_LO_B = 8'h57;
    // reset values
    localparam logic [2:0] RATIO_RESET = 3'h3;
    localparam logic [14:0] DIVISOR_RESET = 15'h0001;
    // source codes
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    // new-clock cycles waited before change-over
    localparam logic [3:0] SETTLE_CYCLES = 4'hA;
    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } oscd_req_t;
endpackage

//--- tb/oscd_ctrl_assertions.sv
// port-level checks for the oscillator control block
// assumes a bind from the bench, one clock domain
module oscd_ctrl_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire oscd_pkg::oscd_req_t bus_req,
    input wire logic [15:0] rdata,
    // straps and events
    input wire logic switch_config_bit,
    input wire logic fail_safe_monitor_event,
    // observed controls
    input wire logic [2:0] active_source,
    input wire logic [2:0] switch_target,
    input wire logic switch_busy,
    input wire logic pll_run,
    input wire logic [1:0] primary_submode,
    input wire logic [3:0] pll_postscale_div,
    input wire logic [1:0] pll_postscale_field,
    input wire logic [14:0] half_period_divisor,
    input wire logic divider_bypass
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // fail event followed by a control register read
    sequence s_fail_read;
        fail_safe_monitor_event ##1 (bus_req.rd && bus_req.addr == 3'h0);
    endsequence
    // a real switch starting
    sequence s_start;
        $rose(switch_busy) && switch_target != active_source;
    endsequence
    property p_fail_read;
        s_fail_read |=> rdata[3];
    endproperty
    a_fail_read: assert property (p_fail_read)
        else $error("fail flag not seen on read");
    property p_settle;
        s_start |=> switch_busy [*8];
    endproperty
    a_settle: assert property (p_settle)
        else $error("switch finished too early");
    property p_done;
        $fell(switch_busy) && !switch_config_bit
            |-> active_source == switch_target;
    endproperty
    a_done: assert property (p_done)
        else $error("current source not updated at completion");
    property p_off_busy;
        switch_config_bit |-> !switch_busy;
    endproperty
    a_off_busy: assert property (p_off_busy)
        else $error("request pending with switching disabled");
    property p_off_target;
        switch_config_bit |-> switch_target == active_source;
    endproperty
    a_off_target: assert property (p_off_target)
        else $error("next source acts with switching disabled");
    property p_pll_run;
        active_source == 3'h1 || active_source == 3'h3 |-> pll_run;
    endproperty
    a_pll_run: assert property (p_pll_run)
        else $error("pll stopped in a pll mode");
    property p_post;
        pll_postscale_div == (4'h1 << pll_postscale_field);
    endproperty
    a_post: assert property (p_post)
        else $error("postscale divide wrong");
    property p_bypass;
        divider_bypass == (half_period_divisor == 15'h0000);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass does not follow zero divisor");
    property p_submode;
        $past(reset, 2) == 1'b0 && !$past(reset)
            |-> $stable(primary_submode);
    endproperty
    a_submode: assert property (p_submode)
        else $error("primary submode changed at run time");
endmodule

//--- tb/testbench.sv
// self-checking bench for the oscillator control block
// assumes reads answer one cycle after the strobe
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // clock, reset, register port
    logic clk_sys, reset;
    oscd_pkg::oscd_req_t bus_req;
    logic [15:0] rdata;
    // straps, events, oscillator status
    logic [2:0] boot_source_config;
    logic switch_config_bit, pin_lock_one_way;
    logic [1:0] primary_submode_config;
    logic fail_safe_monitor_event, interrupt_event;
    logic new_osc_stable_async, new_clock_tick_async, pll_lock_async;
    // outputs
    logic [2:0] active_source, switch_target, cpu_ratio_log2;
    logic [2:0] divider_source_field;
    logic switch_busy, primary_sleep_keep, secondary_osc_enable, pll_run;
    logic pin_map_lock, divider_bypass;
    logic [1:0] primary_submode, pll_postscale_field;
    logic [3:0] pll_postscale_div;
    logic [5:0] fast_rc_tune_code;
    logic [14:0] half_period_divisor;
    logic [8:0] fraction_addend;
    int n_errors = 0;
    int num_checks = 0;
    oscd_ctrl uut (.clk_sys, .reset, .bus_req, .rdata, .boot_source_config,
        .switch_config_bit, .pin_lock_one_way, .primary_submode_config,
        .fail_safe_monitor_event, .interrupt_event, .new_osc_stable_async,
        .new_clock_tick_async, .pll_lock_async, .active_source,
        .switch_target, .switch_busy, .primary_sleep_keep,
        .secondary_osc_enable, .pll_run, .primary_submode, .pin_map_lock,
        .cpu_ratio_log2, .divider_source_field, .pll_postscale_div,
        .pll_postscale_field, .fast_rc_tune_code, .half_period_divisor,
        .fraction_addend, .divider_bypass);
    // 100 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // strobe stays up until the next call or idle
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask
    task automatic idle();
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        #1;
    endtask
    // data sampled only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [15:0] e,
        input logic [15:0] m);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        idle();
        chk("read data", e, rdata & m);
    endtask
    // keyed writes to the high and low byte
    task automatic hi(input logic [2:0] n);
        wr(3'h0, 16'h7800);
        wr(3'h0, 16'h9A00);
        wr(3'h0, {5'h00, n, 8'h00});
        idle();
    endtask
    task automatic lo(input logic [7:0] v);
        wr(3'h0, 16'h0046);
        wr(3'h0, 16'h0057);
        wr(3'h0, {8'h00, v});
        idle();
    endtask
    // strobe dropped here so the preceding write stays one cycle
    task automatic irq();
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        interrupt_event <= 1'b1;
        @(posedge clk_sys);
        interrupt_event <= 1'b0;
        idle();
    endtask
    // each tick is a toggle, two cycles apart for the synchroniser
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (2) @(posedge clk_sys);
            new_clock_tick_async <= ~new_clock_tick_async;
        end
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    task automatic do_reset(input logic [2:0] b, input logic off,
        input logic ow);
        @(posedge clk_sys);
        reset <= 1'b1;
        boot_source_config <= b;
        switch_config_bit <= off;
        pin_lock_one_way <= ow;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_reset_vals();
        chk("active", 16'h0004, 16'(active_source));
        rd(3'h0, 16'h4400, 16'hFFFF);
        rd(3'h1, 16'h3000, 16'hFFFF);
        rd(3'h3, 16'h0001, 16'hFFFF);
        rd(3'h7, 16'h0000, 16'hFFFF);
        @(posedge clk_sys);
        primary_submode_config <= 2'h2;
        idle();
        chk("submode", 16'h0001, 16'(primary_submode));
    endtask
    task automatic t_low_bits();
        lo(8'h06);
        chk("keep", 16'h0001, 16'(primary_sleep_keep));
        chk("sec", 16'h0001, 16'(secondary_osc_enable));
        wr(3'h0, 16'h0040);
        idle();
        rd(3'h0, 16'h4406, 16'hFFFF);
        lo(8'h40);
        lo(8'h00);
        chk("lock", 16'h0001, 16'(pin_map_lock));
        @(posedge clk_sys);
        fail_safe_monitor_event <= 1'b1;
        rd(3'h0, 16'h4448, 16'hFFFF);
        @(posedge clk_sys);
        fail_safe_monitor_event <= 1'b0;
        lo(8'h48);
        rd(3'h0, 16'h4448, 16'hFFFF);
        lo(8'h40);
        rd(3'h0, 16'h4440, 16'hFFFF);
    endtask
    task automatic t_switch();
        hi(3'h3);
        lo(8'h41);
        ticks(0);
        chk("busy", 16'h0001, 16'(switch_busy));
        rd(3'h0, 16'h4341, 16'hFFFF);
        ticks(9);
        chk("busy nine", 16'h0001, 16'(switch_busy));
        ticks(1);
        chk("busy done", 16'h0000, 16'(switch_busy));
        rd(3'h0, 16'h3360, 16'hFFFF);
        chk("pll src", 16'h0001, 16'(pll_run));
        // lock bit must drop while leaving a PLL source
        hi(3'h2);
        lo(8'h41);
        ticks(0);
        rd(3'h0, 16'h3241, 16'hFFFF);
        ticks(10);
        rd(3'h0, 16'h2240, 16'hFFFF);
        hi(3'h2);
        lo(8'h41);
        ticks(0);
        chk("abort", 16'h0000, 16'(switch_busy));
    endtask
    task automatic t_divider();
        for (int n = 0; n < 8; n++) begin
            wr(3'h1, {1'b0, 3'(n), 12'h800});
            idle();
            chk("ratio", 16'(n), 16'(cpu_ratio_log2));
        end
        wr(3'h1, 16'h5000);
        idle();
        chk("ratio off", 16'h0000, 16'(cpu_ratio_log2));
        wr(3'h1, 16'hD800);
        irq();
        chk("roi", 16'h0000, 16'(cpu_ratio_log2));
        rd(3'h1, 16'hD000, 16'hFFFF);
        wr(3'h1, 16'h5800);
        irq();
        chk("no roi", 16'h0005, 16'(cpu_ratio_log2));
        for (int s = 0; s < 6; s++) begin
            wr(3'h1, 16'((s << 8) | ((s % 4) << 6)));
            idle();
            chk("src", 16'(s), 16'(divider_source_field));
            chk("post", 16'(1 << (s % 4)), 16'(pll_postscale_div));
            chk("postf", 16'(s % 4), 16'(pll_postscale_field));
        end
        wr(3'h1, 16'h0020);
        idle();
        chk("force", 16'h0001, 16'(pll_run));
        wr(3'h1, 16'h0000);
        idle();
        chk("no force", 16'h0000, 16'(pll_run));
    endtask
    task automatic t_tune_div();
        wr(3'h2, 16'hFFE0);
        idle();
        chk("tune", 16'h0020, 16'(fast_rc_tune_code));
        rd(3'h2, 16'h0020, 16'hFFFF);
        wr(3'h3, 16'h0000);
        idle();
        chk("bypass", 16'h0001, 16'(divider_bypass));
        wr(3'h3, 16'hFFFF);
        wr(3'h4, 16'hFFFF);
        idle();
        rd(3'h3, 16'h7FFF, 16'hFFFF);
        chk("divisor", 16'h7FFF, 16'(half_period_divisor));
        rd(3'h4, 16'hFF80, 16'hFFFF);
        chk("frac", 16'h01FF, 16'(fraction_addend));
    endtask
    task automatic t_switch_off();
        do_reset(3'h5, 1'b1, 1'b0);
        hi(3'h0);
        lo(8'h41);
        ticks(0);
        chk("target", 16'h0005, 16'(switch_target));
        chk("off busy", 16'h0000, 16'(switch_busy));
        rd(3'h0, 16'h5040, 16'h7041);
        lo(8'h00);
        chk("unlock", 16'h0000, 16'(pin_map_lock));
    endtask
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        stop_test();
    end
    initial begin
        reset = 1'b1;
        bus_req = '0;
        boot_source_config = 3'h4;
        switch_config_bit = 1'b0;
        pin_lock_one_way = 1'b1;
        primary_submode_config = 2'h1;
        fail_safe_monitor_event = 1'b0;
        interrupt_event = 1'b0;
        new_osc_stable_async = 1'b1;
        new_clock_tick_async = 1'b0;
        pll_lock_async = 1'b1;
        do_reset(3'h4, 1'b0, 1'b1);
        t_reset_vals();
        t_low_bits();
        t_switch();
        t_divider();
        t_tune_div();
        t_switch_off();
        stop_test();
    end
endmodule
bind oscd_ctrl oscd_ctrl_assertions u_chk (.clk_sys, .reset, .bus_req, .rdata,
    .switch_config_bit, .fail_safe_monitor_event, .active_source,
    .switch_target, .switch_busy, .pll_run, .primary_submode,
    .pll_postscale_div, .pll_postscale_field, .half_period_divisor,
    .divider_bypass);
